// file: hdl/scc_pkg.sv
// Constants and types for the sealing cycle cooling, hold and calibration block
package scc_pkg;
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned HOLD_BLANK_MS   = 100;
	localparam int unsigned HOLD_SHOW_MS    = 2000;
	localparam int unsigned TENTH_MS        = 100;
	localparam int unsigned CAL_STEP_MS     = 100;
	localparam int unsigned HOLD_BLANK_CYC  = HOLD_BLANK_MS * (CLK_HZ / 1000);
	localparam int unsigned HOLD_SHOW_CYC   = HOLD_SHOW_MS * (CLK_HZ / 1000);
	localparam int unsigned TENTH_CYC       = TENTH_MS * (CLK_HZ / 1000);
	localparam int unsigned CAL_STEP_CYC    = CAL_STEP_MS * (CLK_HZ / 1000);
	localparam logic [9:0]  COOL_ABS_MIN    = 10'h032;
	localparam logic [9:0]  COOL_REL_MIN    = 10'h028;
	localparam logic [9:0]  COOL_REL_MAX    = 10'h064;
	localparam logic [9:0]  COOL_TIME_MAX   = 10'h3E7;
	localparam logic [9:0]  CAL_TEMP_MAX    = 10'h028;
	localparam logic [3:0]  CAL_COUNT_START = 4'hD;
	localparam logic [9:0]  COOL_VAL_RST    = 10'h032;
	localparam logic [9:0]  CAL_TEMP_RST    = 10'h014;
	localparam int unsigned IRQ_CYCLE_END   = 0;
	localparam int unsigned IRQ_CAL_OK      = 1;
	localparam int unsigned IRQ_CAL_ERR     = 2;
	localparam int unsigned IRQ_HOLD_CAP    = 3;
	localparam logic [3:0]  ADDR_CTRL       = 4'h0;
	localparam logic [3:0]  ADDR_COOL_VAL   = 4'h1;
	localparam logic [3:0]  ADDR_STATUS     = 4'h2;
	localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h3;
	localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h4;
	localparam logic [3:0]  ADDR_CAL_TEMP   = 4'h5;
	localparam logic [3:0]  ADDR_HOLD_VAL   = 4'h6;
	typedef enum logic [1:0] {COOL_ABS, COOL_REL, COOL_TIME} scc_cool_mode_t;
	typedef enum logic [1:0] {TC_ON, TC_ON_START, TC_OFF} scc_time_ctl_t;
	typedef enum logic [1:0] {HOLD_OFF, HOLD_ON, HOLD_2S} scc_hold_mode_t;
	typedef enum logic [1:0] {CYC_IDLE, CYC_HEAT, CYC_COOL} scc_cyc_state_t;
	typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_ERR} scc_cal_state_t;
endpackage

// file: hdl/scc_core.sv
// Cooling end, hold capture and zero-calibration sequencing with register port
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module scc_core
	import scc_pkg::*;
#(
	parameter int unsigned HOLD_SHOW_CYCLES = HOLD_SHOW_CYC,
	parameter int unsigned BLANK_CYCLES     = HOLD_BLANK_CYC,
	parameter int unsigned TENTH_CYCLES     = TENTH_CYC,
	parameter int unsigned CAL_STEP_CYCLES  = CAL_STEP_CYC
)
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             irq,
	input  wire logic        heat_active,
	input  wire logic        start_sig,
	input  wire logic [9:0]  actual_temp,
	input  wire logic [9:0]  set_point,
	input  wire logic        key_up,
	input  wire logic        key_down,
	input  wire logic        key_enter,
	input  wire logic        meas_ok,
	output logic             cycle_end,
	output logic             cooling,
	output logic      [9:0]  disp_temp,
	output logic             hold_label,
	output logic             actual_value_label,
	output logic             cal_message,
	output logic      [3:0]  cal_count,
	output logic             cal_error,
	output logic             home_view,
	output logic      [9:0]  disp_cool_value,
	output logic      [15:0] cal_gain
);
	import scc_pkg::*;

	typedef struct packed {
		logic [2:0]  heat_s;
		logic [2:0]  start_s;
		logic [2:0]  up_s;
		logic [2:0]  dn_s;
		logic [2:0]  ent_s;
		logic [1:0]  ok_s;
		scc_cyc_state_t cyc;
		scc_cool_mode_t cmode;
		scc_time_ctl_t  tctl;
		scc_hold_mode_t hmode;
		logic [9:0]  cool_val;
		logic [9:0]  cool_time;
		logic [23:0] tick;
		logic [9:0]  hold_val;
		logic        holding;
		logic [23:0] hold_cnt;
		logic [23:0] blank_cnt;
		scc_cal_state_t cal;
		logic [9:0]  cal_temp;
		logic [3:0]  cal_cnt;
		logic [15:0] gain;
		logic        cyc_end;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_mask;
		logic [15:0] rdata;
		logic [9:0]  disp;
		logic        hold_lbl;
		logic        act_lbl;
	} scc_state_t;

	scc_state_t s_q;
	scc_state_t s_d;

	function automatic logic rise(input logic [2:0] sh);
		rise = sh[1] & ~sh[2];
	endfunction

	// Out-of-range values are dropped, not clamped, so the old setting stays in force
	function automatic logic cool_val_ok(input scc_cool_mode_t m, input logic [9:0] v);
		case (m)
			COOL_ABS:  cool_val_ok = (v >= COOL_ABS_MIN);
			COOL_REL:  cool_val_ok = (v >= COOL_REL_MIN) && (v <= COOL_REL_MAX);
			COOL_TIME: cool_val_ok = (v <= COOL_TIME_MAX);
			default:   cool_val_ok = 1'b0;
		endcase
	endfunction

	logic [19:0] rel_thr;
	logic        cool_done;
	logic [3:0]  ev;

	// Relative threshold: set point times percent over 100, computed without a divider
	always_comb
	begin
		rel_thr = 20'(set_point) * 20'(s_q.cool_val);
	end

	always_comb
	begin
		case (s_q.cmode)
			COOL_ABS:  cool_done = actual_temp < s_q.cool_val;
			COOL_REL:  cool_done = (20'(actual_temp) * 20'h00064) < rel_thr;
			COOL_TIME: cool_done = s_q.cool_time >= s_q.cool_val;
			default:   cool_done = 1'b1;
		endcase
	end

	always_comb
	begin
		s_d = s_q;
		ev = 4'h0;
		s_d.heat_s  = {s_q.heat_s[1:0], heat_active};
		s_d.start_s = {s_q.start_s[1:0], start_sig};
		s_d.up_s    = {s_q.up_s[1:0], key_up};
		s_d.dn_s    = {s_q.dn_s[1:0], key_down};
		s_d.ent_s   = {s_q.ent_s[1:0], key_enter};
		s_d.ok_s    = {s_q.ok_s[0], meas_ok};
		s_d.cyc_end = 1'b0;
		s_d.tick    = (s_q.tick == 24'(TENTH_CYCLES - 1)) ? 24'h000000 : s_q.tick + 24'h000001;

		case (s_q.cyc)
			CYC_IDLE:
			begin
				// With start monitoring, heating only starts a cycle while start is present; start is not checked once heating has begun
				if (s_q.heat_s[1] && (s_q.tctl != TC_ON_START || s_q.start_s[2]))
				begin
					s_d.cyc = CYC_HEAT;
				end
			end
			CYC_HEAT:
			begin
				if (!s_q.heat_s[1])
				begin
					s_d.cyc = CYC_COOL;
					s_d.cool_time = 10'h000;
					s_d.tick = 24'h000000;
					if (s_q.hmode != HOLD_OFF)
					begin
						s_d.hold_val = actual_temp;
						s_d.holding = 1'b1;
						s_d.hold_cnt = 24'h000000;
						s_d.blank_cnt = 24'(BLANK_CYCLES);
						ev[IRQ_HOLD_CAP] = 1'b1;
					end
				end
			end
			CYC_COOL:
			begin
				if (s_q.tick == 24'(TENTH_CYCLES - 1) && s_q.cool_time != COOL_TIME_MAX)
				begin
					s_d.cool_time = s_q.cool_time + 10'h001;
				end
				// Without time control there is no cooling phase to time
				if (s_q.tctl == TC_OFF || cool_done)
				begin
					s_d.cyc = CYC_IDLE;
					s_d.cyc_end = 1'b1;
					ev[IRQ_CYCLE_END] = 1'b1;
				end
			end
			default:
			begin
				s_d.cyc = CYC_IDLE;
			end
		endcase

		if (s_q.blank_cnt != 24'h000000)
		begin
			s_d.blank_cnt = s_q.blank_cnt - 24'h000001;
		end
		// The show time starts only once the blank has ended
		if (s_q.hmode == HOLD_2S && s_q.holding && s_q.blank_cnt == 24'h000000)
		begin
			s_d.hold_cnt = s_q.hold_cnt + 24'h000001;
			if (s_q.hold_cnt == 24'(HOLD_SHOW_CYCLES - 1))
			begin
				s_d.holding = 1'b0;
			end
		end
		if (s_q.hmode == HOLD_OFF)
		begin
			s_d.holding = 1'b0;
		end

		case (s_q.cal)
			CAL_IDLE, CAL_ERR:
			begin
				if (rise(s_q.up_s) && s_q.cal_temp < CAL_TEMP_MAX)
				begin
					s_d.cal_temp = s_q.cal_temp + 10'h001;
				end
				if (rise(s_q.dn_s) && s_q.cal_temp != 10'h000)
				begin
					s_d.cal_temp = s_q.cal_temp - 10'h001;
				end
				if (rise(s_q.ent_s))
				begin
					s_d.cal = CAL_RUN;
					s_d.cal_cnt = CAL_COUNT_START;
					s_d.tick = 24'h000000;
				end
			end
			CAL_RUN:
			begin
				if (!s_q.ok_s[1])
				begin
					s_d.cal = CAL_ERR;
					ev[IRQ_CAL_ERR] = 1'b1;
				end
				else if (s_q.tick == 24'(CAL_STEP_CYCLES - 1))
				begin
					if (s_q.cal_cnt == 4'h0)
					begin
						// Gain is the measured actual temperature minus the calibration temperature
						s_d.gain = {6'h00, actual_temp} - {6'h00, s_q.cal_temp};
						s_d.cal = CAL_IDLE;
						ev[IRQ_CAL_OK] = 1'b1;
					end
					else
					begin
						s_d.cal_cnt = s_q.cal_cnt - 4'h1;
					end
				end
			end
			default:
			begin
				s_d.cal = CAL_IDLE;
			end
		endcase

		s_d.rdata = 16'h0000;
		if (reg_wr)
		begin
			case (reg_addr)
				ADDR_CTRL:
				begin
					s_d.cmode = scc_cool_mode_t'(reg_wdata[1:0]);
					s_d.tctl  = scc_time_ctl_t'(reg_wdata[3:2]);
					s_d.hmode = scc_hold_mode_t'(reg_wdata[5:4]);
				end
				ADDR_COOL_VAL:
				begin
					if (s_q.tctl != TC_OFF && cool_val_ok(s_q.cmode, reg_wdata[9:0]))
					begin
						s_d.cool_val = reg_wdata[9:0];
					end
				end
				ADDR_IRQ_MASK:
				begin
					s_d.irq_mask = reg_wdata[3:0];
				end
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_CTRL:     s_d.rdata = {10'h000, s_q.hmode, s_q.tctl, s_q.cmode};
				ADDR_COOL_VAL: s_d.rdata = {6'h00, s_q.cool_val};
				ADDR_STATUS:   s_d.rdata = {8'h00, s_q.cal_cnt, s_q.cal, s_q.cyc};
				ADDR_IRQ_STAT:
				begin
					s_d.rdata = {12'h000, s_q.irq_stat};
					s_d.irq_stat = 4'h0;
				end
				ADDR_IRQ_MASK: s_d.rdata = {12'h000, s_q.irq_mask};
				ADDR_CAL_TEMP: s_d.rdata = {6'h00, s_q.cal_temp};
				ADDR_HOLD_VAL: s_d.rdata = {6'h00, s_q.hold_val};
				default:       s_d.rdata = 16'h0000;
			endcase
		end
		// Set wins over the read clear so no event is lost
		s_d.irq_stat = s_d.irq_stat | ev;

		// Display fields come from flops so the panel never sees a glitching mux
		s_d.disp     = s_d.holding ? s_d.hold_val : actual_temp;
		s_d.hold_lbl = s_d.holding && (s_d.blank_cnt == 24'h000000);
		s_d.act_lbl  = !s_d.holding;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			s_q <= '0;
			s_q.cyc <= CYC_IDLE;
			s_q.cmode <= COOL_ABS;
			s_q.tctl <= TC_ON;
			s_q.hmode <= HOLD_OFF;
			s_q.cal <= CAL_IDLE;
			s_q.cool_val <= COOL_VAL_RST;
			s_q.cal_temp <= CAL_TEMP_RST;
			s_q.act_lbl <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign reg_rdata          = s_q.rdata;
	assign irq                = |(s_q.irq_stat & s_q.irq_mask);
	assign cycle_end          = s_q.cyc_end;
	assign cooling            = (s_q.cyc == CYC_COOL);
	assign disp_temp          = s_q.disp;
	assign hold_label         = s_q.hold_lbl;
	assign actual_value_label = s_q.act_lbl;
	assign cal_message        = (s_q.cal == CAL_RUN);
	assign cal_count          = s_q.cal_cnt;
	assign cal_error          = (s_q.cal == CAL_ERR);
	assign home_view          = (s_q.cal == CAL_IDLE);
	assign disp_cool_value    = s_q.cool_val;
	assign cal_gain           = s_q.gain;
endmodule

`default_nettype wire

// file: dv/scc_core_sva.sv
// Port checker for the cooling, hold and calibration block
`timescale 1ns/1ps
`default_nettype none
module scc_core_chk
	import scc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire logic       heat_active,
	input wire logic       start_sig,
	input wire logic       cycle_end,
	input wire logic       cooling,
	input wire logic       hold_label,
	input wire logic       actual_value_label,
	input wire logic       cal_message,
	input wire logic [3:0] cal_count,
	input wire logic       cal_error,
	input wire logic       home_view
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_cool_after_heat: assert property ($fell(heat_active) && start_sig |-> ##[1:5] cooling)
		else $error("no cooling after heating");
	a_end_from_cool: assert property (cycle_end |-> $past(cooling))
		else $error("cycle end outside cooling");
	a_end_single: assert property (cycle_end |=> !cycle_end)
		else $error("cycle end longer than one cycle");
	a_hold_excl: assert property (hold_label |-> !actual_value_label)
		else $error("hold and actual labels together");
	a_blank_time: assert property ($fell(actual_value_label) |-> !hold_label [*4] ##[1:3] hold_label)
		else $error("hold blank length wrong");
	a_cal_start: assert property ($rose(cal_message) |-> cal_count == 4'hD)
		else $error("calibration count does not start at 13");
	a_cal_step: assert property (cal_message && $past(cal_message)
		|-> cal_count == $past(cal_count) || cal_count == $past(cal_count) - 4'h1)
		else $error("calibration count step wrong");
	a_err_view: assert property (cal_error |-> !home_view && !cal_message)
		else $error("error shown with home or calibration view");
	c_cycle: cover property (cycle_end);
	c_cal_err: cover property ($rose(cal_error));
	c_hold: cover property ($fell(actual_value_label));
endmodule
bind scc_core scc_core_chk u_chk (.sys_clk, .srst, .heat_active, .start_sig, .cycle_end,
	.cooling, .hold_label, .actual_value_label, .cal_message, .cal_count, .cal_error,
	.home_view);
`default_nettype wire

// file: dv/scc_band_model.sv
// Behavioural heatsealing band: heating state, temperature, measurement health
`timescale 1ns/1ps
`default_nettype none
module scc_band_model
(
	input  wire logic       sys_clk,
	input  wire logic       heat_req,
	input  wire logic       fail,
	output logic            heat_active,
	output logic      [9:0] actual_temp,
	output logic            meas_ok
);
	logic [2:0] lag_q = 3'h0;
	initial
	begin
		heat_active = 1'h0;
		actual_temp = 10'h014;
		meas_ok     = 1'h1;
	end
	// Peak holds a few cycles after heating so the capture sees it
	always @(posedge sys_clk)
	begin
		heat_active <= heat_req;
		meas_ok     <= !fail;
		lag_q       <= heat_req ? 3'h6 : lag_q - {2'h0, lag_q != 3'h0};
		if (heat_req)
			actual_temp <= 10'h0C8;
		else if (lag_q == 3'h0 && actual_temp > 10'h014)
			actual_temp <= actual_temp - 10'h00A;
	end
endmodule
`default_nettype wire

// file: dv/test_sealing_cycle_cooling_hold_calibration.sv
// Self-checking bench for the cooling, hold and calibration block
`timescale 1ns/1ps
`default_nettype none
module test_sealing_cycle_cooling_hold_calibration;
	import scc_pkg::*;
	logic        sys_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, start_sig = 1'h1;
	logic        heat_req = 1'h0, fail = 1'h0, irq, heat_active, meas_ok, cycle_end, cooling;
	logic        hold_label, actual_value_label, cal_message, cal_error, home_view;
	logic [3:0]  reg_addr = 4'h0, cal_count;
	logic [15:0] reg_wdata = 16'h0000, v, reg_rdata, cal_gain;
	logic [9:0]  set_point = 10'h0A0, actual_temp, disp_temp, disp_cool_value, q;
	logic [2:0]  kv = 3'h0;
	logic [15:0] cv [3] = '{16'h0064, 16'h0032, 16'h0003};
	logic [9:0]  lo [3] = '{10'h03C, 10'h028, 10'h00E};
	logic [9:0]  hi [3] = '{10'h063, 10'h04F, 10'h014};
	wire  [2:0]  obs = {cal_error, cal_message, cycle_end};
	int          n_fail = 0, n_compared = 0, k;
	always #50 sys_clk = ~sys_clk;
	scc_core #(.HOLD_SHOW_CYCLES(20), .BLANK_CYCLES(5), .TENTH_CYCLES(4), .CAL_STEP_CYCLES(4))
	u_scc_core (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.heat_active, .start_sig, .actual_temp, .set_point, .key_up(kv[0]), .key_down(kv[1]),
		.key_enter(kv[2]), .meas_ok, .cycle_end, .cooling, .disp_temp, .hold_label,
		.actual_value_label, .cal_message, .cal_count, .cal_error, .home_view,
		.disp_cool_value, .cal_gain);
	scc_band_model u_scc_band_model (.sys_clk, .heat_req, .fail, .heat_active, .actual_temp,
		.meas_ok);
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task stop_test;
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge sys_clk);
		reg_wr    <= 1'h0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge sys_clk);
		reg_rd   <= 1'h0;
		#1 v = reg_rdata;
	endtask
	// Keys pass a synchroniser, so a press is held long enough to be seen
	task key(input int i);
		@(posedge sys_clk);
		kv[i] <= 1'h1;
		repeat (6) @(posedge sys_clk);
		kv[i] <= 1'h0;
		repeat (6) @(posedge sys_clk);
	endtask
	task heat(input logic s);
		@(posedge sys_clk);
		start_sig <= s;
		heat_req  <= 1'h1;
		repeat (10) @(posedge sys_clk);
		heat_req  <= 1'h0;
		cyc(12);
	endtask
	task wait_sig(input int i, input logic val);
		k = 0;
		while (obs[i] !== val && k < 300)
		begin
			cyc(1);
			k++;
		end
		if (k == 300)
		begin
			n_fail++;
			stop_test();
		end
	endtask
	initial
	begin
		repeat (8) @(posedge sys_clk);
		srst <= 1'h0;
		rd(ADDR_CTRL);
		chk("ctrl", v, 16'h0000);
		rd(ADDR_COOL_VAL);
		chk("cool value", v, 16'h0032);
		rd(ADDR_CAL_TEMP);
		chk("cal temp", v, 16'h0014);
		$display("reset test done");
		for (int m = 0; m < 3; m++)
		begin
			wr(ADDR_CTRL, 16'h0020 | 16'(m));
			wr(ADDR_COOL_VAL, cv[m]);
			cyc(1);
			chk("cool shown", disp_cool_value, cv[m]);
			heat(1'h1);
			chk("hold label", hold_label, 16'h0001);
			chk("act label", actual_value_label, 16'h0000);
			chk("held temp", disp_temp, 16'h00C8);
			wait_sig(0, 1'h1);
			q = (m == 2) ? 10'(k + 12) : actual_temp;
			chk("cool end", q >= lo[m] && q <= hi[m], 16'h0001);
			if (m == 0)
			begin
				chk("masked irq", irq, 16'h0000);
				wr(ADDR_IRQ_MASK, 16'h000F);
				cyc(1);
				chk("irq", irq, 16'h0001);
				rd(ADDR_IRQ_STAT);
				chk("irq stat", v & 16'h0009, 16'h0009);
				cyc(1);
				chk("irq clear", irq, 16'h0000);
			end
			cyc(30);
			chk("live label", actual_value_label, 16'h0001);
			chk("live temp", disp_temp, actual_temp);
		end
		$display("cooling and hold test done");
		wr(ADDR_CTRL, 16'h0008);
		wr(ADDR_COOL_VAL, 16'h004D);
		rd(ADDR_COOL_VAL);
		chk("cool locked", v, 16'h0003);
		wr(ADDR_CTRL, 16'h0001);
		wr(ADDR_COOL_VAL, 16'h0065);
		rd(ADDR_COOL_VAL);
		chk("cool range", v, 16'h0003);
		wr(ADDR_CTRL, 16'h0006);
		rd(ADDR_IRQ_STAT);
		heat(1'h0);
		cyc(30);
		rd(ADDR_IRQ_STAT);
		chk("no start", v[0], 16'h0000);
		heat(1'h1);
		cyc(30);
		rd(ADDR_IRQ_STAT);
		chk("started", v[0], 16'h0001);
		$display("time control test done");
		repeat (22) key(1);
		rd(ADDR_CAL_TEMP);
		chk("cal low", v, 16'h0000);
		repeat (42) key(0);
		rd(ADDR_CAL_TEMP);
		chk("cal high", v, 16'h0028);
		key(1);
		key(2);
		wait_sig(1, 1'h1);
		chk("cal view", home_view, 16'h0000);
		wait_sig(1, 1'h0);
		chk("cal done", home_view, 16'h0001);
		rd(ADDR_IRQ_STAT);
		chk("cal ok", v[2:1], 16'h0001);
		rd(ADDR_CAL_TEMP);
		chk("cal stored", v, 16'h0027);
		chk("cal gain", cal_gain, 16'hFFED);
		key(2);
		@(posedge sys_clk);
		fail <= 1'h1;
		wait_sig(2, 1'h1);
		chk("err view", home_view, 16'h0000);
		rd(ADDR_IRQ_STAT);
		chk("cal err", v[2:1], 16'h0002);
		@(posedge sys_clk);
		fail <= 1'h0;
		key(2);
		wait_sig(1, 1'h0);
		chk("retry", {cal_error, home_view}, 16'h0001);
		$display("calibration test done");
		stop_test();
	end
endmodule
`default_nettype wire
